/* File: occfg_params.svh */
/*
 * Constants for the output pair one configuration bank: register
 * addresses, reset values, field positions and write masks.
 * Assumes it is included by bare name from the bank and its decoder.
 */
`ifndef OCFG_PARAMS_SVH
`define OCFG_PARAMS_SVH

// Register addresses on the control port
`define OCFG_ROUTE_ADDR   8'h64
`define OCFG_LEVEL_ADDR   8'h65

// Reset values
`define OCFG_ROUTE_RST    8'h20
`define OCFG_LEVEL_RST    8'h20

// Bits that software may change in the route register (bit 0 is read-only)
`define OCFG_ROUTE_WMASK  8'hFE

// Route register fields
`define OCFG_SRC_MSB      7
`define OCFG_SRC_LSB      5
`define OCFG_TOPO_MSB     4
`define OCFG_TOPO_LSB     2
`define OCFG_VCOM_BIT     1
`define OCFG_RSVD_BIT     0

// Drive and level register fields
`define OCFG_DRV_MSB      7
`define OCFG_DRV_LSB      6
`define OCFG_LVL_MSB      5
`define OCFG_LVL_LSB      3
`define OCFG_IMP_BIT      2
`define OCFG_BYPSE_BIT    1
`define OCFG_BW_BIT       0

`endif

/* File: occfg_pkg.sv */
/*
 * Types shared by the output pair one configuration bank and its
 * field decoder. Assumes nothing beyond a SystemVerilog compiler.
 */
package occfg_pkg;

    typedef logic [7:0] occfg_byte_t;   // One control-port register
    typedef logic [2:0] occfg_code_t;   // Three-bit field code

    // Common-mode choice handed to the analog side
    typedef enum logic [1:0] {
        VCOM_REF_0P6,
        VCOM_REF_0P654,
        VCOM_HALF_SUPPLY
    } occfg_vcom_e;

    // Routing of sources to the two output pins
    typedef struct packed {
        logic pos_conv;       // Converter drives positive output
        logic neg_conv;       // Converter drives negative output
        logic pos_byp;        // Negative bypass input to positive output
        logic neg_byp;        // Positive bypass input to negative output
        logic pos_vcom;       // Positive output carries common mode
        logic neg_vcom;       // Negative output carries common mode
        logic ext_sense;      // Second channel negative pin senses externally
        logic single_ended;   // Stereo single-ended pins
        logic reserved;       // Reserved source or topology code held
    } occfg_route_s;

    // Source code carries the bypass path (bypass only or mix)
    function automatic logic occfg_src_bypass(input occfg_code_t src);
        occfg_src_bypass = (src == 3'h2) || (src == 3'h3);
    endfunction : occfg_src_bypass

    // Source code carries the converter chain (converter only or mix)
    function automatic logic occfg_src_conv(input occfg_code_t src);
        occfg_src_conv = (src == 3'h1) || (src == 3'h3);
    endfunction : occfg_src_conv

endpackage : occfg_pkg

/* File: occfg_field_if.sv */
/*
 * Carrier between the register bank and its field decoder: raw
 * register contents outward, decoded analog controls back.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/10ps
interface occfg_field_if;
    import occfg_pkg::*;

    occfg_byte_t  route_cfg;   // Route register contents
    occfg_byte_t  level_cfg;   // Drive and level register contents
    logic         ref_1v375;   // Reference runs in its 1.375 V mode
    occfg_route_s route;       // Decoded pin routing
    occfg_vcom_e  vcom;        // Decoded common-mode choice
    logic         level_ok;    // Level code legal for current source

    modport bank (output route_cfg, output level_cfg, output ref_1v375,
                  input route, input vcom, input level_ok);
    modport dec  (input route_cfg, input level_cfg, input ref_1v375,
                  output route, output vcom, output level_ok);
endinterface : occfg_field_if

/* File: occfg_decode.sv */
/*
 * Combinational decode of the two configuration registers into pin
 * routing, common-mode choice and a level legality flag.
 * Assumes its outputs are registered by the bank before use.
 */
`timescale 1ns/10ps
`include "occfg_params.svh"
module occfg_decode (
    occfg_field_if.dec f
);
    import occfg_pkg::*;

    occfg_code_t src;    // Source selector
    occfg_code_t topo;   // Routing topology
    occfg_code_t lvl;    // Positive pin level code
    logic        conv;   // Converter chain active
    logic        byp;    // Bypass path active

    assign src  = f.route_cfg[`OCFG_SRC_MSB:`OCFG_SRC_LSB];
    assign topo = f.route_cfg[`OCFG_TOPO_MSB:`OCFG_TOPO_LSB];
    assign lvl  = f.level_cfg[`OCFG_LVL_MSB:`OCFG_LVL_LSB];
    assign conv = occfg_src_conv(src);
    assign byp  = occfg_src_bypass(src);

    // Routing decode; split sources override topology entirely
    always_comb begin
        f.route = '0;
        case (src)
            3'h4: begin                          // see R04
                f.route.pos_conv = 1'b1;
                f.route.neg_byp  = 1'b1;
            end
            3'h5: begin                          // see R04
                f.route.pos_byp  = 1'b1;
                f.route.neg_conv = 1'b1;
            end
            3'h1, 3'h2, 3'h3: begin              // see R03
                case (topo)                      // see R06
                    3'h0, 3'h1: begin
                        f.route.pos_conv     = conv;
                        f.route.neg_conv     = conv;
                        f.route.pos_byp      = byp;
                        f.route.neg_byp      = byp;
                        f.route.single_ended = (topo == 3'h1);
                    end
                    3'h2: begin                  // Mono on positive pin
                        f.route.pos_conv = conv;
                        f.route.pos_byp  = byp;
                    end
                    3'h3: begin                  // Mono on negative pin
                        f.route.neg_conv = conv;
                        f.route.neg_byp  = byp;
                    end
                    3'h4, 3'h5: begin            // see R07
                        f.route.pos_conv  = conv;
                        f.route.pos_byp   = byp;
                        f.route.neg_vcom  = 1'b1;
                        f.route.ext_sense = (topo == 3'h5);
                    end
                    3'h6: begin                  // see R07
                        f.route.neg_conv = conv;
                        f.route.neg_byp  = byp;
                        f.route.pos_vcom = 1'b1;
                    end
                    default: begin               // Reserved topology: pins quiet
                        f.route.reserved = 1'b1;
                    end
                endcase
            end
            default: begin                       // Reserved source: pins quiet
                f.route.reserved = 1'b1;
            end
        endcase
    end

    // Common-mode choice follows the reference mode when bit is clear
    always_comb begin
        if (f.route_cfg[`OCFG_VCOM_BIT]) begin   // see R09
            f.vcom = VCOM_HALF_SUPPLY;
        end else if (f.ref_1v375) begin
            f.vcom = VCOM_REF_0P654;
        end else begin
            f.vcom = VCOM_REF_0P6;
        end
    end

    // Level legality: flags codes software must not use in this mode
    always_comb begin
        case (lvl)
            3'h2:    f.level_ok = (src == 3'h2);
            3'h3:    f.level_ok = byp;
            3'h4:    f.level_ok = 1'b1;
            3'h5:    f.level_ok = byp;
            3'h6:    f.level_ok = byp && !f.level_cfg[`OCFG_IMP_BIT];
            default: f.level_ok = 1'b0;          // Reserved codes
        endcase
    end

endmodule : occfg_decode

/* File: occfg_bank.sv */
/*
 * Register bank for output pair one: route register and drive/level
 * register on the device control port, with registered analog controls.
 * Assumes the control-port front end delivers one-cycle write and read
 * strobes with address and data synchronous to core_clk.
 */
// Operation
// R01: Route register at 0x64, resets 0x20
// R02: Drive/level register at 0x65, resets 0x20
// R03: Source 1 converter, 2 bypass, 3 mix
// R04: Sources 4 and 5 split converter/bypass pins
// R05: Software avoids source codes 0, 6, 7
// R06: Topology 0 diff, 1 SE, 2/3 mono
// R07: Topology 4-6 pseudo-differential, 7 reserved
// R08: Topology ignored for source 4 or 5
// R09: Common-mode bit picks reference fraction or half-supply
// R10: Route bit 0 reserved, reads zero
// R11: Drive field picks line, headphone, 4ohm, high-DR
// R12: Level resets to 0 dB; avoid 0,1,7
// R13: Gain codes 2, 3, 5 need bypass source
// R14: Level code 6 needs bypass and 4.4k
// R15: Impedance bit picks 4.4k or 20k
// R16: Bypass input differential or single-ended
// R17: Bandwidth bit picks 24 kHz or 96 kHz
// R18: Read-back returns writes; reserved bits unchanged
`timescale 1ns/10ps
`include "occfg_params.svh"
module occfg_bank (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic [7:0]          reg_addr,
    input  wire occfg_pkg::occfg_byte_t reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output      occfg_pkg::occfg_byte_t reg_rd_data,
    output      logic                reg_rd_valid,
    input  wire logic                ref_mode_1v375,
    output      logic                pos_from_conv,
    output      logic                neg_from_conv,
    output      logic                pos_from_bypass,
    output      logic                neg_from_bypass,
    output      logic                pos_carries_vcom,
    output      logic                neg_carries_vcom,
    output      logic                ext_sense_en,
    output      logic                single_ended_out,
    output      logic                route_reserved,
    output      logic [1:0]          vcom_sel,
    output      logic [1:0]          pos_drive,
    output      logic [2:0]          pos_level,
    output      logic                level_valid,
    output      logic                bypass_imp_20k,
    output      logic                bypass_single_ended,
    output      logic                conv_wide_bw
);
    import occfg_pkg::*;

    occfg_byte_t  route_reg;     // Route register
    occfg_byte_t  route_next;
    occfg_byte_t  level_reg;     // Drive and level register
    occfg_byte_t  level_next;
    occfg_byte_t  rd_data_reg;   // Read data latch
    occfg_byte_t  rd_data_next;
    logic         rd_valid_reg;  // Read answer strobe
    logic         rd_valid_next;
    occfg_route_s route_o_reg;   // Registered routing controls
    occfg_route_s route_o_next;
    occfg_vcom_e  vcom_reg;      // Registered common-mode choice
    occfg_vcom_e  vcom_next;
    logic         lvl_ok_reg;    // Registered level legality
    logic         lvl_ok_next;
    logic         hit_route;     // Address selects route register
    logic         hit_level;     // Address selects drive/level register

    occfg_field_if fif ();

    assign fif.route_cfg = route_reg;
    assign fif.level_cfg = level_reg;
    assign fif.ref_1v375 = ref_mode_1v375;

    // Decoder stays combinational; its results are flopped below
    occfg_decode u_decode (
        .f (fif.dec)
    );

    assign hit_route = (reg_addr == `OCFG_ROUTE_ADDR);
    assign hit_level = (reg_addr == `OCFG_LEVEL_ADDR);

    // Register writes; unmapped addresses are ignored
    always_comb begin
        route_next = route_reg;
        level_next = level_reg;
        if (reg_wr && hit_route) begin
            // Reserved bit keeps its value whatever software sends
            route_next = (reg_wdata & `OCFG_ROUTE_WMASK)
                       | (route_reg & ~`OCFG_ROUTE_WMASK);  // see R10 see R18
        end
        if (reg_wr && hit_level) begin
            level_next = reg_wdata;                         // see R18
        end
    end

    // Read path; answer one cycle after the strobe, zero if unmapped
    always_comb begin
        rd_valid_next = reg_rd;
        rd_data_next  = rd_data_reg;
        if (reg_rd) begin
            if (hit_route) begin
                rd_data_next = route_reg;                   // see R18
            end else if (hit_level) begin
                rd_data_next = level_reg;                   // see R18
            end else begin
                rd_data_next = '0;
            end
        end
    end

    // Decoded controls take one cycle so all analog outputs come from flops
    always_comb begin
        route_o_next = fif.route;
        vcom_next    = fif.vcom;
        lvl_ok_next  = fif.level_ok;
    end

    // State registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            route_reg    <= `OCFG_ROUTE_RST;                // see R01
            level_reg    <= `OCFG_LEVEL_RST;                // see R02
            rd_data_reg  <= '0;
            rd_valid_reg <= 1'b0;
            route_o_reg  <= '0;
            vcom_reg     <= VCOM_REF_0P6;
            lvl_ok_reg   <= 1'b1;
        end else begin
            route_reg    <= route_next;
            level_reg    <= level_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            route_o_reg  <= route_o_next;
            vcom_reg     <= vcom_next;
            lvl_ok_reg   <= lvl_ok_next;
        end
    end

    // Output mapping
    assign reg_rd_data         = rd_data_reg;
    assign reg_rd_valid        = rd_valid_reg;
    assign pos_from_conv       = route_o_reg.pos_conv;
    assign neg_from_conv       = route_o_reg.neg_conv;
    assign pos_from_bypass     = route_o_reg.pos_byp;
    assign neg_from_bypass     = route_o_reg.neg_byp;
    assign pos_carries_vcom    = route_o_reg.pos_vcom;
    assign neg_carries_vcom    = route_o_reg.neg_vcom;
    assign ext_sense_en        = route_o_reg.ext_sense;
    assign single_ended_out    = route_o_reg.single_ended;
    assign route_reserved      = route_o_reg.reserved;        // see R05
    assign vcom_sel            = vcom_reg;
    // Drive, level and bypass bits feed the analog side straight from flops
    assign pos_drive           = level_reg[`OCFG_DRV_MSB:`OCFG_DRV_LSB];  // see R11
    assign pos_level           = level_reg[`OCFG_LVL_MSB:`OCFG_LVL_LSB];  // see R12
    assign level_valid         = lvl_ok_reg;                  // see R13 see R14
    assign bypass_imp_20k      = level_reg[`OCFG_IMP_BIT];    // see R15
    assign bypass_single_ended = level_reg[`OCFG_BYPSE_BIT];  // see R16
    assign conv_wide_bw        = level_reg[`OCFG_BW_BIT];     // see R17

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence wr_route_s;
        reg_wr && hit_route;
    endsequence

    sequence rd_route_s;
        reg_rd && hit_route && !(reg_wr && hit_route);
    endsequence

    route_reset_val_a: assert property ( // see R01
        $fell(reset) |-> route_reg == 8'h20)
        else $error("route register not at reset value");

    level_reset_val_a: assert property ( // see R02
        $fell(reset) |-> level_reg == 8'h20)
        else $error("level register not at reset value");

    route_readback_a: assert property ( // see R18
        wr_route_s ##1 rd_route_s |=> reg_rd_valid &&
            reg_rd_data == ($past(reg_wdata, 2) & 8'hFE))
        else $error("route read-back mismatch");

    level_write_a: assert property ( // see R18
        reg_wr && hit_level |=> level_reg == $past(reg_wdata))
        else $error("level register did not take write");

    rsvd_bit_zero_a: assert property ( // see R10
        route_reg[0] == 1'b0)
        else $error("reserved route bit not zero");

    read_latency_a: assert property ( // see R18
        reg_rd && !hit_route && !hit_level |=> reg_rd_valid && reg_rd_data == 8'h00)
        else $error("unmapped read not answered with zero");

    split_route_a: assert property ( // see R04
        route_reg[7:5] == 3'h4 && $stable(route_reg) |=>
            pos_from_conv && neg_from_bypass && !neg_from_conv && !pos_from_bypass)
        else $error("split source four misrouted");

    topo_ignored_a: assert property ( // see R08
        route_reg[7:5] == 3'h5 && $stable(route_reg) |=>
            !pos_carries_vcom && !neg_carries_vcom && !route_reserved)
        else $error("topology acted in split source mode");

    vcom_half_a: assert property ( // see R09
        route_reg[1] && $stable(route_reg) |=> vcom_sel == VCOM_HALF_SUPPLY)
        else $error("common mode not half supply");

    level_gate_a: assert property ( // see R14
        level_reg[5:3] == 3'h6 && level_reg[2] && $stable(level_reg) |=> !level_valid)
        else $error("level code six accepted with 20k input");

    bw_follow_a: assert property ( // see R17
        reg_wr && hit_level |=> conv_wide_bw == $past(reg_wdata[0]))
        else $error("bandwidth bit not applied");

endmodule : occfg_bank

/* File: tb_top.sv */
/*
 * Self-checking testbench for the output pair one configuration bank.
 * Drives the control-port strobes at the falling edge of core_clk and
 * compares read-back and configuration outputs against expected values.
 * Assumes the bank answers reads one edge after the strobe and that
 * decoded routing outputs lag register writes by one further edge.
 */
`timescale 1ns/10ps
`include "occfg_params.svh"
module tb_top;
    import occfg_pkg::*;

    logic        core_clk;         // 100 MHz system clock
    logic        reset;            // Asynchronous, active high
    logic [7:0]  reg_addr;         // Register address
    occfg_byte_t reg_wdata;        // Write data
    logic        reg_wr;           // Write strobe
    logic        reg_rd;           // Read strobe
    occfg_byte_t reg_rd_data;      // Read answer
    logic        reg_rd_valid;     // Read answer strobe
    logic        ref_mode_1v375;   // Reference mode input
    logic        pos_from_conv, neg_from_conv, pos_from_bypass, neg_from_bypass;
    logic        pos_carries_vcom, neg_carries_vcom, ext_sense_en, single_ended_out;
    logic        route_reserved, level_valid, bypass_imp_20k;
    logic        bypass_single_ended, conv_wide_bw;
    logic [1:0]  vcom_sel;         // Decoded common-mode choice
    logic [1:0]  pos_drive;        // Positive pin drive field
    logic [2:0]  pos_level;        // Positive pin level field
    int          fail_count;       // Mismatches seen
    int          check_count;      // Comparisons made
    int          cycle_count;      // Cycles since start, for the hang guard

    // Expected {pos_conv, neg_conv, pos_byp, neg_byp, reserved} per source code
    logic [4:0] src_exp [0:7] = '{5'h01, 5'h18, 5'h06, 5'h1E, 5'h12, 5'h0C, 5'h01, 5'h01};
    // Expected {pos_conv, neg_conv, single_ended, neg_vcom, ext_sense, pos_vcom, reserved}
    logic [6:0] topo_exp [0:7] = '{7'h60, 7'h70, 7'h40, 7'h20, 7'h48, 7'h4C, 7'h22, 7'h01};

    occfg_bank occfg_bank_inst (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .ref_mode_1v375(ref_mode_1v375), .pos_from_conv(pos_from_conv),
        .neg_from_conv(neg_from_conv), .pos_from_bypass(pos_from_bypass),
        .neg_from_bypass(neg_from_bypass), .pos_carries_vcom(pos_carries_vcom),
        .neg_carries_vcom(neg_carries_vcom), .ext_sense_en(ext_sense_en),
        .single_ended_out(single_ended_out), .route_reserved(route_reserved),
        .vcom_sel(vcom_sel), .pos_drive(pos_drive), .pos_level(pos_level),
        .level_valid(level_valid), .bypass_imp_20k(bypass_imp_20k),
        .bypass_single_ended(bypass_single_ended), .conv_wide_bw(conv_wide_bw)
    );

    // Free-running clock, 10 ns period
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard: the whole run needs well under 1000 cycles
    always @(posedge core_clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 2000) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: run did not finish in time", $time);
            give_verdict();
        end
    end

    // Compare one value and report at once on mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count = check_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One-cycle write strobe; register holds the value after the taking edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
    endtask : wr

    // One-cycle read strobe, bounded wait for the answer, then compare
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge core_clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        while (reg_rd_valid !== 1'b1 && n < 3) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk({7'h00, reg_rd_valid}, 8'h01, "read answer strobe");
        chk(reg_rd_data, exp, "read data");
    endtask : rd

    // Write taken on one edge, read of the same address on the very next edge
    task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b1;
        @(negedge core_clk);
        reg_rd    = 1'b0;
        chk({7'h00, reg_rd_valid}, 8'h01, "back-to-back answer strobe");
        chk(reg_rd_data, exp, "back-to-back read data");
    endtask : wr_rd

    // Set source and level, then look at the legality flag once it has settled
    task automatic lvl_chk(input logic [7:0] route, input logic [7:0] level, input logic exp);
        wr(`OCFG_ROUTE_ADDR, route);
        wr(`OCFG_LEVEL_ADDR, level);
        @(negedge core_clk);
        chk({7'h00, level_valid}, {7'h00, exp}, "level legality");
    endtask : lvl_chk

    // Closing report; the only place the run ends
    task automatic give_verdict();
        $display("checks made %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        int i;
        logic [7:0] v;
        fail_count = 0;
        check_count = 0;
        cycle_count = 0;
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ref_mode_1v375 = 1'b0;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);

        // Reset values and their decode
        rd(`OCFG_ROUTE_ADDR, 8'h20);
        rd(`OCFG_LEVEL_ADDR, 8'h20);
        chk({3'h0, pos_from_conv, neg_from_conv, 3'h0}, 8'h18, "reset source");
        chk({pos_drive, pos_level, 3'h0}, 8'h20, "reset drive level");
        chk({5'h0, bypass_imp_20k, bypass_single_ended, conv_wide_bw}, 8'h00,
            "reset level bits");
        $display("test reset values done");

        // Every source code, with read-back of the written value
        for (i = 0; i < 8; i++) begin
            v = {i[2:0], 5'h00};
            wr(`OCFG_ROUTE_ADDR, v);
            @(negedge core_clk);
            chk({3'h0, pos_from_conv, neg_from_conv, pos_from_bypass, neg_from_bypass,
                route_reserved}, {3'h0, src_exp[i]}, "source decode");
            rd(`OCFG_ROUTE_ADDR, v);
        end
        $display("test source codes done");

        // Every topology code with the converter source
        for (i = 0; i < 8; i++) begin
            wr(`OCFG_ROUTE_ADDR, {3'h1, i[2:0], 2'h0});
            @(negedge core_clk);
            chk({1'b0, pos_from_conv, neg_from_conv, single_ended_out,
                neg_carries_vcom, ext_sense_en, pos_carries_vcom, route_reserved},
                {1'b0, topo_exp[i]}, "topology decode");
        end
        $display("test topology codes done");

        // Common-mode choice in both reference modes; bit 0 stays clear
        wr(`OCFG_ROUTE_ADDR, 8'h20);
        @(negedge core_clk);
        chk({6'h0, vcom_sel}, 8'h00, "vcom fraction");
        ref_mode_1v375 = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({6'h0, vcom_sel}, 8'h01, "vcom 1v375 fraction");
        wr(`OCFG_ROUTE_ADDR, 8'hFF);
        @(negedge core_clk);
        chk({6'h0, vcom_sel}, 8'h02, "vcom half supply");
        rd(`OCFG_ROUTE_ADDR, 8'hFE);
        ref_mode_1v375 = 1'b0;
        $display("test common mode done");

        // Drive, level and single-bit fields, each value read back
        for (i = 0; i < 8; i++) begin
            v = {i[1:0], i[2:0], i[0], i[1], i[2]};
            wr(`OCFG_LEVEL_ADDR, v);
            chk({pos_drive, pos_level, bypass_imp_20k, bypass_single_ended, conv_wide_bw},
                v, "level fields");
            rd(`OCFG_LEVEL_ADDR, v);
        end
        $display("test level fields done");

        // Unmapped addresses answer reads with zero and do not disturb the bank
        rd(8'h63, 8'h00);
        wr(8'h66, 8'h55);
        rd(`OCFG_ROUTE_ADDR, 8'hFE);
        rd(`OCFG_LEVEL_ADDR, 8'hFF);
        $display("test unmapped done");

        // Split source five over a pseudo-differential topology, written and read at once
        wr_rd(`OCFG_ROUTE_ADDR, 8'hB0, 8'hB0);
        chk({4'h0, pos_carries_vcom, neg_carries_vcom, ext_sense_en, neg_from_conv},
            8'h01, "split five ignores topology");
        // Level codes against the source mode and the bypass impedance
        lvl_chk(8'h20, 8'h10, 1'b0);
        lvl_chk(8'h40, 8'h10, 1'b1);
        lvl_chk(8'h60, 8'h10, 1'b0);
        lvl_chk(8'h60, 8'h18, 1'b1);
        lvl_chk(8'h20, 8'h28, 1'b0);
        lvl_chk(8'h40, 8'h30, 1'b1);
        lvl_chk(8'h40, 8'h34, 1'b0);
        lvl_chk(8'h20, 8'h20, 1'b1);
        $display("test level legality done");

        // Reset in mid-run restores both registers
        @(negedge core_clk);
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        rd(`OCFG_ROUTE_ADDR, 8'h20);
        rd(`OCFG_LEVEL_ADDR, 8'h20);
        $display("test mid-run reset done");

        give_verdict();
    end
endmodule : tb_top
